// ==== src/flm_pkg.sv ====
// shared constants and types for the flash led mode controller
package flm_pkg;

	// ==========================================
	// clock and timing
	localparam int CLK_HZ     = 40_000_000;
	localparam int TIMEOUT_MS = 820;
	localparam int STEP_US    = 54_600;
	localparam int SETTLE_US  = 50;
	localparam int TMR_W      = 26;
	localparam int SETTLE_W   = 12;

	localparam logic [TMR_W-1:0] TIMEOUT_CYC =
		TMR_W'(TIMEOUT_MS * (CLK_HZ / 1000));
	localparam logic [TMR_W-1:0] STEP_CYC =
		TMR_W'(STEP_US * (CLK_HZ / 1_000_000));
	localparam logic [SETTLE_W-1:0] SETTLE_CYC =
		SETTLE_W'(SETTLE_US * (CLK_HZ / 1_000_000));

	// ==========================================
	// register port and map
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	localparam logic [ADDR_W-1:0] ADDR_CUR  = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_TCTL = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_HW_FLASH_TRIGGER = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_IND  = 3'h4;

	// ==========================================
	// fields
	localparam int CUR_W       = 5;
	localparam int TCODE_W     = 4;
	localparam int IND_W       = 3;
	localparam int TSEL_BIT    = 4;
	localparam int SW_BIT      = 0;
	localparam int TO_FLAG_BIT = 1;

	localparam logic [CUR_W-1:0] CUR_OFF   = 5'h00;
	localparam logic [CUR_W-1:0] TORCH_MIN = 5'h01;
	localparam logic [CUR_W-1:0] TORCH_MAX = 5'h0B;
	localparam logic [CUR_W-1:0] FLASH_MIN = 5'h0C;
	localparam logic [IND_W-1:0] IND_OFF   = 3'h0;

	// ==========================================
	// operating modes
	typedef enum logic [2:0] {
		FLM_SHUTDOWN,
		FLM_STANDBY,
		FLM_INDICATOR,
		FLM_TORCH,
		FLM_FLASH
	} flm_mode_t;

endpackage

// ==== src/flm_pin_sync.sv ====
// three-stage synchroniser with second/third stage agreement filter
`timescale 1ns/1ps
module flm_pin_sync
(
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic pin_in,
	output logic      pin_q
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic q_reg;

	// ==========================================
	// sync chain
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// ==========================================
	// accept only when two stages agree
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			q_reg <= 1'b0;
		else if (s2_reg == s3_reg)
			q_reg <= s3_reg;
	end

	assign pin_q = q_reg;

endmodule

// ==== src/flm_flash_timer.sv ====
// flash duration down-counter with load, hold and expiry pulse
`timescale 1ns/1ps
module flm_flash_timer
	import flm_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             start,
	input  wire logic             hold,
	input  wire logic [TMR_W-1:0] load_val,
	output logic                  busy,
	output logic                  expired
);

	logic [TMR_W-1:0] count_reg;
	logic [TMR_W-1:0] count_next;

	// ==========================================
	// counter
	always_comb
	begin
		if (start)
			count_next = load_val;
		else if (!hold)
			count_next = '0;
		else if (count_reg != '0)
			count_next = count_reg - TMR_W'(1);
		else
			count_next = count_reg;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

	assign busy    = (count_reg != '0);
	assign expired = hold && !start && (count_reg == TMR_W'(1));

endmodule

// ==== src/flm_mode_ctrl.sv ====
// mode and flash timing control of a photo-flash led driver
// Behaviour
// R1: direct mode: activate low shuts down; enables 00/01/10/11 standby/ind/torch/flash
// R2: every mode is reachable straight from standby
// R3: serial mode: host arms current then triggers by pin or strobe bit
// R4: activate low keeps power switch and both sinks off
// R5: standby keeps logic alive, converter idle, sinks off, bus answering
// R6: serial codes 1 to 11 are torch levels; torch resistor ignored
// R7: torch code lights torch; code 0 or flash entry ends torch
// R8: serial codes 12 to 31 are flash levels
// R9: direct torch lasts while enables select torch, no limit
// R10: direct flash lasts while selected, forced off after 820 ms
// R11: timed flash only in serial mode, selected by timer bit 4
// R12: timed flash starts on strobe bit write or strobe pin rise
// R13: timed flash trigger is edge sensitive
// R14: timed duration is 820 ms minus code times 54.6 ms
// R15: timed expiry sets no flag; new trigger accepted at once
// R16: serial indicator level is 3-bit code; indicator resistor ignored
// R17: lowered flash current settles within 50 us
// R18: interface select sampled on activate rise; 0 serial, 1 direct
// R19: only serial mode may run indicator together with torch or flash
// R20: untimed flash limited to 820 ms; expiry sets status bit 1
// R21: strobe pin falling clears the strobe bit
// R22: untimed serial flash lasts while either strobe held
// R23: code zero leaves main led off; nothing selected means standby
`timescale 1ns/1ps
module flm_mode_ctrl
	import flm_pkg::*;
#(
	parameter logic [TMR_W-1:0] TIMEOUT_CYCLES = TIMEOUT_CYC,
	parameter logic [TMR_W-1:0] STEP_CYCLES    = STEP_CYC
)
(
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	input  wire logic              chip_activate,
	input  wire logic              interface_select,
	input  wire logic              enable_line_one,
	input  wire logic              enable_line_two,
	input  wire logic              hw_flash_trigger,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic [DATA_W-1:0] bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic      [DATA_W-1:0] bus_rdata,
	output logic                   power_switch_en,
	output logic                   main_sink_en,
	output logic                   main_torch_on,
	output logic                   main_flash_on,
	output logic      [CUR_W-1:0]  main_current_code,
	output logic                   ind_sink_en,
	output logic      [IND_W-1:0]  ind_current_code,
	output logic                   use_set_resistors,
	output logic                   fast_discharge,
	output logic                   timeout_fault_flag,
	output flm_mode_t              op_mode
);

	logic                act_q;
	logic                ifsel_q;
	logic                en1_q;
	logic                en2_q;
	logic                hw_q;
	logic                act_d_reg;
	logic                hw_d_reg;
	logic                act_rise;
	logic                hw_rise;
	logic                hw_fall;
	logic                direct_reg;
	logic [CUR_W-1:0]    cur_reg;
	logic                tsel_reg;
	logic [TCODE_W-1:0]  tcode_reg;
	logic                sw_bit_reg;
	logic [IND_W-1:0]    ind_reg;
	logic                to_flag_reg;
	logic                dir_block_reg;
	logic                flash_reg;
	logic                flash_next;
	logic                flash_start;
	logic                torch_reg;
	logic                torch_next;
	logic                ind_on_reg;
	logic                ind_next;
	logic [CUR_W-1:0]    code_reg;
	logic [IND_W-1:0]    ind_code_reg;
	flm_mode_t           mode_reg;
	flm_mode_t           mode_next;
	logic [DATA_W-1:0]   rdata_reg;
	logic [DATA_W-1:0]   rd_val;
	logic [SETTLE_W-1:0] settle_reg;
	logic                wr_ok;
	logic                wr_cur;
	logic                wr_tctl;
	logic                wr_hw_flash_trigger;
	logic                wr_ind;
	logic                sw_trig;
	logic                flash_armed;
	logic                torch_code;
	logic                timed;
	logic                tmr_busy;
	logic                tmr_expired;
	logic [TMR_W-1:0]    step_mul;
	logic [TMR_W-1:0]    tmr_load;

	// ==========================================
	// pin synchronisers
	flm_pin_sync u_sync_act (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (chip_activate),
		.pin_q    (act_q)
	);
	flm_pin_sync u_sync_ifsel (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (interface_select),
		.pin_q    (ifsel_q)
	);
	flm_pin_sync u_sync_en1 (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (enable_line_one),
		.pin_q    (en1_q)
	);
	flm_pin_sync u_sync_en2 (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (enable_line_two),
		.pin_q    (en2_q)
	);
	flm_pin_sync u_sync_hw (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (hw_flash_trigger),
		.pin_q    (hw_q)
	);

	// ==========================================
	// edges and interface select capture
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			act_d_reg <= 1'b0;
			hw_d_reg  <= 1'b0;
		end
		else
		begin
			act_d_reg <= act_q;
			hw_d_reg  <= hw_q;
		end
	end

	assign act_rise = act_q && !act_d_reg;
	assign hw_rise  = hw_q && !hw_d_reg; // R12 R13
	assign hw_fall  = !hw_q && hw_d_reg;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			direct_reg <= 1'b0;
		else if (act_rise)
			direct_reg <= ifsel_q; // R18
	end

	// ==========================================
	// register writes
	assign wr_ok   = bus_wr && act_q && !direct_reg; // R5
	assign wr_cur  = wr_ok && (bus_addr == ADDR_CUR);
	assign wr_tctl = wr_ok && (bus_addr == ADDR_TCTL);
	assign wr_hw_flash_trigger = wr_ok && (bus_addr == ADDR_HW_FLASH_TRIGGER);
	assign wr_ind  = wr_ok && (bus_addr == ADDR_IND);
	assign sw_trig = wr_hw_flash_trigger && bus_wdata[SW_BIT]; // R12

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cur_reg   <= CUR_OFF;
			tsel_reg  <= 1'b0;
			tcode_reg <= '0;
			ind_reg   <= IND_OFF;
		end
		else if (!act_q)
		begin
			cur_reg   <= CUR_OFF;
			tsel_reg  <= 1'b0;
			tcode_reg <= '0;
			ind_reg   <= IND_OFF;
		end
		else
		begin
			if (wr_cur)
				cur_reg <= bus_wdata[CUR_W-1:0]; // R3
			if (wr_tctl)
			begin
				tsel_reg  <= bus_wdata[TSEL_BIT]; // R11
				tcode_reg <= bus_wdata[TCODE_W-1:0];
			end
			if (wr_ind)
				ind_reg <= bus_wdata[IND_W-1:0]; // R16
		end
	end

	// software strobe bit: a write that sets wins over a pin fall
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			sw_bit_reg <= 1'b0;
		else if (!act_q)
			sw_bit_reg <= 1'b0;
		else if (wr_hw_flash_trigger)
			sw_bit_reg <= bus_wdata[SW_BIT];
		else if (hw_fall && !direct_reg)
			sw_bit_reg <= 1'b0; // R21
	end

	// ==========================================
	// flash timer
	assign timed       = tsel_reg && !direct_reg; // R11
	assign flash_armed = (cur_reg >= FLASH_MIN); // R8
	assign torch_code  = (cur_reg >= TORCH_MIN) && (cur_reg <= TORCH_MAX); // R6
	assign step_mul    = STEP_CYCLES * TMR_W'(tcode_reg);
	assign tmr_load    = timed ? (TIMEOUT_CYCLES - step_mul) : TIMEOUT_CYCLES; // R14 R20

	flm_flash_timer u_timer (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.start    (flash_start),
		.hold     (flash_reg),
		.load_val (tmr_load),
		.busy     (tmr_busy),
		.expired  (tmr_expired)
	);

	// ==========================================
	// flash decision
	always_comb
	begin
		flash_start = 1'b0;
		flash_next  = 1'b0;
		if (direct_reg)
		begin
			flash_start = !flash_reg && en2_q && en1_q && !to_flag_reg && !dir_block_reg; // R1 R2
			flash_next  = flash_start || (flash_reg && en2_q && en1_q && !tmr_expired); // R10
		end
		else
		begin
			flash_start = !flash_reg && flash_armed && !to_flag_reg && (sw_trig || hw_rise); // R3
			flash_next  = flash_start || (flash_reg && flash_armed && !tmr_expired
				&& (timed || sw_bit_reg || hw_q)); // R13 R22
		end
		flash_next  = flash_next && act_q; // R4
		flash_start = flash_start && act_q;
	end

	// timeout fault flag: set on untimed expiry; activate low clears first, set wins over the other clears
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			to_flag_reg <= 1'b0;
		else if (!act_q)
			to_flag_reg <= 1'b0;
		else if (flash_reg && tmr_expired && !timed)
			to_flag_reg <= 1'b1; // R20 R15
		else if (wr_cur && (bus_wdata[CUR_W-1:0] == CUR_OFF))
			to_flag_reg <= 1'b0;
		else if (direct_reg && !en1_q && !en2_q)
			to_flag_reg <= 1'b0;
	end

	// direct flash block: set on time-out, cleared when enable one drops or activate goes low
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			dir_block_reg <= 1'b0;
		else if (!act_q || !en1_q)
			dir_block_reg <= 1'b0;
		else if (direct_reg && flash_reg && tmr_expired)
			dir_block_reg <= 1'b1; // R10
	end

	// ==========================================
	// torch, indicator and mode
	always_comb
	begin
		if (direct_reg)
		begin
			torch_next = en2_q && !en1_q; // R1 R9
			ind_next   = en1_q && !en2_q; // R19
		end
		else
		begin
			torch_next = torch_code; // R6 R7
			ind_next   = (ind_reg != IND_OFF); // R16
		end
		torch_next = torch_next && act_q && !flash_next; // R7
		ind_next   = ind_next && act_q;
		if (!act_q)
			mode_next = FLM_SHUTDOWN; // R1
		else if (flash_next)
			mode_next = FLM_FLASH;
		else if (torch_next)
			mode_next = FLM_TORCH;
		else if (ind_next)
			mode_next = FLM_INDICATOR;
		else
			mode_next = FLM_STANDBY; // R23
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flash_reg    <= 1'b0;
			torch_reg    <= 1'b0;
			ind_on_reg   <= 1'b0;
			code_reg     <= CUR_OFF;
			ind_code_reg <= IND_OFF;
			mode_reg     <= FLM_SHUTDOWN;
		end
		else
		begin
			flash_reg    <= flash_next;
			torch_reg    <= torch_next;
			ind_on_reg   <= ind_next;
			code_reg     <= (!direct_reg && (flash_next || torch_next)) ? cur_reg : CUR_OFF; // R23
			ind_code_reg <= (!direct_reg && ind_next) ? ind_reg : IND_OFF;
			mode_reg     <= mode_next;
		end
	end

	// ==========================================
	// fast current reduction window
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			settle_reg <= '0;
		else if (flash_reg && wr_cur && (bus_wdata[CUR_W-1:0] < cur_reg)
			&& (bus_wdata[CUR_W-1:0] >= FLASH_MIN))
			settle_reg <= SETTLE_CYC; // R17
		else if (settle_reg != '0)
			settle_reg <= settle_reg - SETTLE_W'(1);
	end

	// ==========================================
	// register read
	always_comb
	begin
		rd_val = '0;
		case (bus_addr)
			ADDR_CUR:  rd_val[CUR_W-1:0] = cur_reg;
			ADDR_TCTL:
			begin
				rd_val[TSEL_BIT]      = tsel_reg;
				rd_val[TCODE_W-1:0]   = tcode_reg;
			end
			ADDR_HW_FLASH_TRIGGER: rd_val[SW_BIT] = sw_bit_reg;
			ADDR_STAT: rd_val[TO_FLAG_BIT] = to_flag_reg;
			ADDR_IND:  rd_val[IND_W-1:0] = ind_reg;
			default:   rd_val = '0;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_reg <= '0;
		else if (bus_rd)
			rdata_reg <= rd_val;
		else
			rdata_reg <= '0;
	end

	// ==========================================
	// outputs
	assign bus_rdata          = rdata_reg;
	assign power_switch_en    = flash_reg || torch_reg; // R4 R5
	assign main_sink_en       = flash_reg || torch_reg;
	assign main_torch_on      = torch_reg;
	assign main_flash_on      = flash_reg;
	assign main_current_code  = code_reg;
	assign ind_sink_en        = ind_on_reg;
	assign ind_current_code   = ind_code_reg;
	assign use_set_resistors  = direct_reg; // R6 R16
	assign fast_discharge     = (settle_reg != '0);
	assign timeout_fault_flag = to_flag_reg;
	assign op_mode            = mode_reg;

	// ==========================================
	// checks
	a_shutdown_sinks_off: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		!act_q |=> !power_switch_en && !main_sink_en && !ind_sink_en)
		else $error("outputs on while activate low");

	a_standby_all_idle: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
		op_mode == FLM_STANDBY |-> !power_switch_en && !ind_sink_en && !main_flash_on)
		else $error("standby with converter or sink active");

	a_direct_torch_sel: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		act_q && direct_reg && en2_q && !en1_q |=> main_torch_on && !main_flash_on)
		else $error("direct torch decode wrong");

	a_pin_fall_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // R21
		act_q && !direct_reg && hw_fall && !wr_hw_flash_trigger |=> !sw_bit_reg)
		else $error("strobe bit not cleared on pin fall");

	a_untimed_to_flag: assert property (@(posedge core_clk) disable iff (sys_rst) // R20
		act_q && flash_reg && tmr_expired && !timed |=> to_flag_reg && !main_flash_on)
		else $error("untimed expiry did not set flag");

	a_timed_no_flag: assert property (@(posedge core_clk) disable iff (sys_rst) // R15
		act_q && flash_reg && tmr_expired && timed && !to_flag_reg
		|=> !to_flag_reg && !main_flash_on)
		else $error("timed expiry flagged or flash kept");

	a_serial_torch_code: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
		act_q && !direct_reg && torch_code && !flash_next
		|=> main_torch_on && main_current_code == $past(cur_reg))
		else $error("torch code not applied");

	a_flash_ends_torch: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		main_flash_on |-> !main_torch_on)
		else $error("torch and flash together");

	a_select_capture: assert property (@(posedge core_clk) disable iff (sys_rst) // R18
		act_rise |=> direct_reg == $past(ifsel_q) ##1 $stable(direct_reg))
		else $error("interface select not captured");

endmodule

// ==== test/flm_host_model.sv ====
// host model driving the pins and register port of the mode controller
`timescale 1ns/1ps
module flm_host_model
	import flm_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic [DATA_W-1:0] bus_rdata,
	output logic                   chip_activate,
	output logic                   interface_select,
	output logic                   enable_line_one,
	output logic                   enable_line_two,
	output logic                   hw_flash_trigger,
	output logic      [ADDR_W-1:0] bus_addr,
	output logic      [DATA_W-1:0] bus_wdata,
	output logic                   bus_wr,
	output logic                   bus_rd
);
	initial
	begin
		{chip_activate, interface_select, enable_line_one, enable_line_two} = 4'h0;
		{hw_flash_trigger, bus_wr, bus_rd} = 3'h0;
		bus_addr = 3'h0;
		bus_wdata = 8'h00;
	end

	// =====================================
	// pins: select moves only while activate is low
	task automatic set_pins(input logic act, input logic sel, input logic [1:0] en,
		input logic trig);
		@(posedge core_clk);
		if (chip_activate !== 1'b1)
			interface_select <= sel;
		chip_activate <= act;
		{enable_line_two, enable_line_one} <= en;
		hw_flash_trigger <= trig;
	endtask

	// =====================================
	// register port; idle lines carry the inverse of the last value
	task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
		bus_addr <= ~a;
		bus_wdata <= ~d;
	endtask

	task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		bus_addr <= ~a;
		@(negedge core_clk);
		d = bus_rdata;
	endtask
endmodule

// ==== test/flm_mode_ctrl_tb.sv ====
// self-checking testbench of the flash led mode controller
`timescale 1ns/1ps
module flm_mode_ctrl_tb;
	import flm_pkg::*;
	localparam int TO_CYC = 200;
	localparam int STEP = 10;
	logic              core_clk, sys_rst;
	logic              chip_activate, interface_select, enable_line_one, enable_line_two;
	logic              hw_flash_trigger, bus_wr, bus_rd;
	logic [ADDR_W-1:0] bus_addr;
	logic [DATA_W-1:0] bus_wdata, bus_rdata, rd;
	logic              power_switch_en, main_sink_en, main_torch_on, main_flash_on;
	logic [CUR_W-1:0]  main_current_code;
	logic              ind_sink_en, use_set_resistors, fast_discharge, timeout_fault_flag;
	logic [IND_W-1:0]  ind_current_code;
	flm_mode_t         op_mode;
	int                err_total = 0;
	int                tests_run = 0;

	flm_mode_ctrl #(.TIMEOUT_CYCLES(TMR_W'(TO_CYC)), .STEP_CYCLES(TMR_W'(STEP))) DUT (
		.core_clk(core_clk), .sys_rst(sys_rst), .chip_activate(chip_activate),
		.interface_select(interface_select), .enable_line_one(enable_line_one),
		.enable_line_two(enable_line_two), .hw_flash_trigger(hw_flash_trigger),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .power_switch_en(power_switch_en), .main_sink_en(main_sink_en),
		.main_torch_on(main_torch_on), .main_flash_on(main_flash_on),
		.main_current_code(main_current_code), .ind_sink_en(ind_sink_en),
		.ind_current_code(ind_current_code), .use_set_resistors(use_set_resistors),
		.fast_discharge(fast_discharge), .timeout_fault_flag(timeout_fault_flag),
		.op_mode(op_mode));

	flm_host_model host (
		.core_clk(core_clk), .bus_rdata(bus_rdata), .chip_activate(chip_activate),
		.interface_select(interface_select), .enable_line_one(enable_line_one),
		.enable_line_two(enable_line_two), .hw_flash_trigger(hw_flash_trigger),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));

	// =====================================
	// helpers
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("ERROR at %0t: %s", $time, msg);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic dur(input int exp, input string msg);
		int n;
		n = 0;
		for (int i = 0; i < 12 && main_flash_on !== 1'b1; i++) @(posedge core_clk);
		check(main_flash_on === 1'b1, "flash did not start");
		while (main_flash_on === 1'b1 && n < 1000)
		begin
			@(posedge core_clk);
			n++;
		end
		check(n >= exp - 3 && n <= exp + 3, msg);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// =====================================
	// scenarios
	task automatic t_shutdown();
		host.set_pins(1'b0, 1'b0, 2'b11, 1'b1);
		cyc(8);
		check(op_mode === FLM_SHUTDOWN, "not shut down");
		check({power_switch_en, main_sink_en, ind_sink_en} === 3'h0, "sinks active");
		host.reg_write(ADDR_CUR, 8'h05);
		cyc(3);
		check(main_torch_on === 1'b0, "write taken in shutdown");
	endtask

	task automatic t_direct();
		flm_mode_t exp_mode [4] = '{FLM_STANDBY, FLM_INDICATOR, FLM_TORCH, FLM_FLASH};
		host.set_pins(1'b1, 1'b1, 2'b00, 1'b0);
		cyc(8);
		check(use_set_resistors === 1'b1, "direct mode not selected");
		for (int e = 1; e < 4; e++)
		begin
			host.set_pins(1'b1, 1'b1, 2'(e), 1'b0);
			cyc(8);
			check(op_mode === exp_mode[e], "enable decode");
			check(ind_sink_en === (e == 1), "indicator sink");
			check({main_torch_on, main_flash_on} === {e == 2, e == 3}, "main led mode");
			check(power_switch_en === (e > 1), "converter state");
			host.set_pins(1'b1, 1'b1, 2'b00, 1'b0);
			cyc(8);
			check(op_mode === FLM_STANDBY && main_sink_en === 1'b0, "standby");
		end
		host.set_pins(1'b1, 1'b1, 2'b10, 1'b0);
		cyc(TO_CYC + 60);
		check(main_torch_on === 1'b1, "torch limited in time");
		host.set_pins(1'b1, 1'b1, 2'b11, 1'b0);
		dur(TO_CYC, "direct flash time-out");
		check(timeout_fault_flag === 1'b1, "time-out flag");
		host.set_pins(1'b1, 1'b1, 2'b00, 1'b0);
		cyc(8);
		check(timeout_fault_flag === 1'b0, "flag not cleared");
	endtask

	task automatic t_serial();
		host.set_pins(1'b1, 1'b0, 2'b00, 1'b0);
		cyc(8);
		check(op_mode === FLM_STANDBY && use_set_resistors === 1'b0, "serial standby");
		host.reg_write(ADDR_CUR, 8'h01);
		cyc(2);
		check(main_torch_on === 1'b1 && main_current_code === 5'h01, "torch 1");
		host.reg_write(ADDR_CUR, 8'h0B);
		cyc(2);
		check(op_mode === FLM_TORCH && main_current_code === 5'h0B, "torch 11");
		host.reg_write(ADDR_IND, 8'h07);
		cyc(2);
		check(ind_sink_en === 1'b1 && ind_current_code === 3'h7, "indicator");
		check(main_torch_on === 1'b1, "torch beside indicator");
		host.reg_write(ADDR_CUR, 8'h00);
		cyc(2);
		check(main_torch_on === 1'b0 && main_current_code === 5'h00, "torch off");
		host.reg_write(ADDR_IND, 8'h00);
		cyc(2);
		check(op_mode === FLM_STANDBY && ind_sink_en === 1'b0, "back to standby");
	endtask

	task automatic t_timed();
		host.reg_write(ADDR_CUR, 8'h0C);
		host.reg_write(ADDR_TCTL, 8'h10);
		host.reg_write(ADDR_HW_FLASH_TRIGGER, 8'h01);
		dur(TO_CYC, "timed code 0");
		host.reg_write(ADDR_TCTL, 8'h1F);
		host.reg_write(ADDR_HW_FLASH_TRIGGER, 8'h01);
		dur(TO_CYC - 15 * STEP, "timed code 15");
		host.set_pins(1'b1, 1'b0, 2'b00, 1'b1);
		dur(TO_CYC - 15 * STEP, "pin held past timed end");
		check(timeout_fault_flag === 1'b0, "timed expiry flagged");
		host.set_pins(1'b1, 1'b0, 2'b00, 1'b0);
		cyc(8);
	endtask

	task automatic t_untimed();
		host.reg_write(ADDR_TCTL, 8'h00);
		host.reg_write(ADDR_CUR, 8'h1F);
		host.set_pins(1'b1, 1'b0, 2'b00, 1'b1);
		cyc(8);
		check(main_flash_on === 1'b1 && main_current_code === 5'h1F, "pin flash");
		host.reg_write(ADDR_CUR, 8'h0C);
		cyc(3);
		check(fast_discharge === 1'b1, "no discharge on lowering");
		host.reg_write(ADDR_HW_FLASH_TRIGGER, 8'h01);
		host.set_pins(1'b1, 1'b0, 2'b00, 1'b0);
		cyc(8);
		check(main_flash_on === 1'b0, "flash outlived strobe");
		host.reg_read(ADDR_HW_FLASH_TRIGGER, rd);
		check(rd === 8'h00, "strobe bit kept");
		host.reg_write(ADDR_HW_FLASH_TRIGGER, 8'h01);
		dur(TO_CYC, "untimed time-out");
		host.reg_read(ADDR_STAT, rd);
		check(rd === 8'h02, "status flag");
		host.reg_write(ADDR_HW_FLASH_TRIGGER, 8'h01);
		cyc(3);
		check(main_flash_on === 1'b0, "flash while flagged");
		host.reg_write(ADDR_CUR, 8'h00);
		host.reg_read(ADDR_STAT, rd);
		check(rd === 8'h00, "flag not cleared");
		host.reg_read(3'h7, rd);
		check(rd === 8'h00, "unmapped read");
	endtask

	// =====================================
	// clock, reset, sequence, watchdog
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial
	begin
		sys_rst = 1'b1;
		cyc(3);
		sys_rst <= 1'b0;
		t_shutdown();
		t_direct();
		t_shutdown();
		t_serial();
		t_timed();
		t_untimed();
		summarize();
	end

	initial
	begin
		cyc(20000);
		err_total++;
		$display("ERROR at %0t: watchdog expired", $time);
		summarize();
	end
endmodule
